/* hdl/cellbus_regs.sv */
// register bank for the cell-bus configuration and receive interrupt status
`timescale 1ns/100ps
module cellbus_regs (
   input  wire logic                           i_clk,         // device clock
   input  wire logic                           i_srst,        // synchronous reset, high
   input  wire logic                           i_atm_mode,    // 1: atm uni, 0: clear-channel
   input  wire logic [7:0]                     i_addr,        // register address
   input  wire logic                           i_wr,          // write strobe, one cycle
   input  wire logic                           i_rd,          // read strobe, one cycle
   input  wire logic [7:0]                     i_wdata,       // write data
   input  wire cellbus_regs_pkg::rx_events_t   i_rx_events,   // one-cycle event pulses
   input  wire logic                           i_rx_full,     // rx fifo full from datapath
   input  wire logic                           i_rx_empty,    // rx fifo empty from datapath
   output logic [7:0]                          o_rdata,       // read data, valid a cycle after i_rd
   output cellbus_regs_pkg::cellbus_cfg_t      o_cfg,         // decoded settings
   output logic                                o_rx_fifo_clr, // one-cycle rx fifo clear
   output logic                                o_irq,         // interrupt request, level
   output logic                                o_ovr_risk,    // full: next non-read may overrun
   output logic                                o_und_risk     // empty: next read may underrun
);
   // register state
   logic [7:0]                     cfg_q, cfg_d;         // configuration register
   logic [7:0]                     irq_q, irq_d;         // enables, reset bit and flags
   logic [7:0]                     rdata_q, rdata_d;     // read data holding
   logic                           clr_q, clr_d;         // fifo clear pulse
   logic                           irq_out_q, irq_out_d; // interrupt request
   logic                           ovr_q, ovr_d;         // overrun risk
   logic                           und_q, und_d;         // underrun risk
   cellbus_regs_pkg::cellbus_cfg_t cfg_out_q, cfg_out_d; // decoded settings
   logic                           wr_cfg, wr_irq, rd_irq; // decoded strobes

   // address decode
   // only full-address matches count; a write to any other address is ignored, a read returns zero
   always_comb begin
      wr_cfg = i_wr && (i_addr == cellbus_regs_pkg::CFG_OFFSET);
      wr_irq = i_wr && (i_addr == cellbus_regs_pkg::IRQ_OFFSET);
      rd_irq = i_rd && (i_addr == cellbus_regs_pkg::IRQ_OFFSET);
   end

   // configuration register: next value
   // writes land in either mode, so software can prepare the cell bus before atm mode starts
   // unused bits are masked on the way in, so the read path needs no gating
   always_comb begin
      cfg_d = cfg_q; // hold by default
      // configuration write; bits 7-6 unused stay zero
      if (wr_cfg) begin
         cfg_d = i_wdata & cellbus_regs_pkg::CFG_WR_MASK;
      end
   end

   // configuration register: storage only
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cfg_q <= cellbus_regs_pkg::CFG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // read data: next value
   // the image is taken before the clear-on-read, so a flag is seen once before it drops
   always_comb begin
      rdata_d = rdata_q; // held until the next read
      if (i_rd) begin
         if (i_addr == cellbus_regs_pkg::CFG_OFFSET) begin
            rdata_d = cfg_q;
         end else if (rd_irq) begin
            rdata_d = irq_q;
         end else begin
            rdata_d = 8'h00; // unmapped reads as zero
         end
      end
   end

   // read data: storage only
   // zero after reset, the same as an unmapped read
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // interrupt register, fifo clear pulse and interrupt request: next values
   // one process for all three, since the request is formed from the next register image
   always_comb begin
      irq_d = irq_q; // hold by default
      clr_d = 1'b0;  // clear is a one-cycle pulse
      // enables and reset bit; underrun enable stays zero
      if (wr_irq) begin
         irq_d[cellbus_regs_pkg::IRQ_FIFO_RST_BIT] = i_wdata[cellbus_regs_pkg::IRQ_FIFO_RST_BIT];
         irq_d[cellbus_regs_pkg::IRQ_OVR_EN_BIT]   = i_wdata[cellbus_regs_pkg::IRQ_OVR_EN_BIT];
         irq_d[cellbus_regs_pkg::IRQ_RUNT_EN_BIT]  = i_wdata[cellbus_regs_pkg::IRQ_RUNT_EN_BIT];
         // a 0-to-1 write on the reset bit clears the fifo, only in atm mode
         clr_d = i_atm_mode && i_wdata[cellbus_regs_pkg::IRQ_FIFO_RST_BIT]
                 && !irq_q[cellbus_regs_pkg::IRQ_FIFO_RST_BIT];
      end
      irq_d[cellbus_regs_pkg::IRQ_UND_EN_BIT] = 1'b0;
      irq_d[7] = 1'b0;
      // a read of this register clears its status flags
      // the read image was already taken in the read data process
      if (rd_irq) begin
         irq_d[cellbus_regs_pkg::IRQ_OVR_STS_BIT]  = 1'b0;
         irq_d[cellbus_regs_pkg::IRQ_UND_STS_BIT]  = 1'b0;
         irq_d[cellbus_regs_pkg::IRQ_RUNT_STS_BIT] = 1'b0;
      end
      // events set after the clear so a same-cycle event wins; ignored outside atm mode
      // a flag lost to a colliding read would hide a real fault, hence the set priority
      if (i_atm_mode) begin
         if (i_rx_events.overrun) begin
            irq_d[cellbus_regs_pkg::IRQ_OVR_STS_BIT] = 1'b1;
         end
         if (i_rx_events.underrun) begin
            irq_d[cellbus_regs_pkg::IRQ_UND_STS_BIT] = 1'b1;
         end
         if (i_rx_events.runt) begin
            irq_d[cellbus_regs_pkg::IRQ_RUNT_STS_BIT] = 1'b1;
         end
      end
      // interrupt: flag and enable, from the next register image
      irq_out_d = i_atm_mode &&
         ((irq_d[cellbus_regs_pkg::IRQ_OVR_STS_BIT]  && irq_d[cellbus_regs_pkg::IRQ_OVR_EN_BIT])  ||
          (irq_d[cellbus_regs_pkg::IRQ_UND_STS_BIT]  && irq_d[cellbus_regs_pkg::IRQ_UND_EN_BIT])  ||
          (irq_d[cellbus_regs_pkg::IRQ_RUNT_STS_BIT] && irq_d[cellbus_regs_pkg::IRQ_RUNT_EN_BIT]));
   end

   // interrupt group: storage only
   // the fifo reset bit is stored so a later write can see the 0-to-1 edge
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         irq_q     <= cellbus_regs_pkg::IRQ_RESET;
         clr_q     <= 1'b0;
         irq_out_q <= 1'b0;
      end else begin
         irq_q     <= irq_d;
         clr_q     <= clr_d;
         irq_out_q <= irq_out_d;
      end
   end

   // fifo risk warnings: next values
   // the levels are copied one cycle late, so a warning may trail the fifo by a cycle
   always_comb begin
      ovr_d = i_atm_mode && i_rx_full;
      und_d = i_atm_mode && i_rx_empty;
   end

   // fifo risk warnings: storage only
   // cleared by reset like every other output
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ovr_q <= 1'b0;
         und_q <= 1'b0;
      end else begin
         ovr_q <= ovr_d;
         und_q <= und_d;
      end
   end

   // decoded settings: next values
   // decoded from the next configuration image, so a write shows after one cycle
   // limitation: a change of mode also reaches o_cfg only one cycle later
   always_comb begin
      // decode settings; clear-channel leaves defaults inactive
      cfg_out_d.multi_device = i_atm_mode && cfg_d[cellbus_regs_pkg::CFG_MULTI_BIT];
      cfg_out_d.cell_level   = i_atm_mode && !cfg_d[cellbus_regs_pkg::CFG_MULTI_BIT]
                               && cfg_d[cellbus_regs_pkg::CFG_HANDSHAKE_BIT];
      cfg_out_d.wide_bus     = i_atm_mode && cfg_d[cellbus_regs_pkg::CFG_WIDE_BIT];
      if (i_atm_mode && cfg_d[cellbus_regs_pkg::CFG_SHORT_BIT]) begin
         cfg_out_d.cell_bytes = cellbus_regs_pkg::CELL_LEN_SHORT;
      end else if (cfg_out_d.wide_bus) begin
         cfg_out_d.cell_bytes = cellbus_regs_pkg::CELL_LEN_WIDE;
      end else begin
         cfg_out_d.cell_bytes = cellbus_regs_pkg::CELL_LEN_NARROW;
      end
      // depth code; outside atm mode the full depth stands
      case (i_atm_mode ? cfg_d[cellbus_regs_pkg::CFG_DEPTH_HI:cellbus_regs_pkg::CFG_DEPTH_LO] : 2'b00)
         2'b00:   cfg_out_d.tx_depth = cellbus_regs_pkg::DEPTH_CODE0;
         2'b01:   cfg_out_d.tx_depth = cellbus_regs_pkg::DEPTH_CODE1;
         2'b10:   cfg_out_d.tx_depth = cellbus_regs_pkg::DEPTH_CODE2;
         2'b11:   cfg_out_d.tx_depth = cellbus_regs_pkg::DEPTH_CODE3;
         default: cfg_out_d.tx_depth = cellbus_regs_pkg::DEPTH_CODE0;
      endcase
   end

   // decoded settings: storage only
   // reset leaves every field zero; the first edge after release loads the decode
   // the datapath must not act on o_cfg while reset is high
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cfg_out_q <= '0;
      end else begin
         cfg_out_q <= cfg_out_d;
      end
   end

   // outputs straight from flip-flops
   always_comb begin
      o_rdata       = rdata_q;
      o_cfg         = cfg_out_q;
      o_rx_fifo_clr = clr_q;
      o_irq         = irq_out_q;
      o_ovr_risk    = ovr_q;
      o_und_risk    = und_q;
   end
endmodule // cellbus_regs

/* hdl/cellbus_regs_pkg.sv */
// package: offsets, field positions, reset values and carriers for the cell-bus register bank
package cellbus_regs_pkg;
   localparam logic [7:0] CFG_OFFSET      = 8'h6a;  // configuration register
   localparam logic [7:0] IRQ_OFFSET      = 8'h6b;  // receive interrupt enable/status
   // configuration field positions
   localparam int CFG_HANDSHAKE_BIT       = 5;
   localparam int CFG_MULTI_BIT           = 4;
   localparam int CFG_SHORT_BIT           = 3;
   localparam int CFG_DEPTH_HI            = 2;
   localparam int CFG_DEPTH_LO            = 1;
   localparam int CFG_WIDE_BIT            = 0;
   localparam logic [7:0] CFG_RESET       = 8'h10;  // multi-device set by default
   localparam logic [7:0] CFG_WR_MASK     = 8'h3f;
   // interrupt register field positions
   localparam int IRQ_FIFO_RST_BIT        = 6;
   localparam int IRQ_OVR_EN_BIT          = 5;
   localparam int IRQ_UND_EN_BIT          = 4;
   localparam int IRQ_RUNT_EN_BIT         = 3;
   localparam int IRQ_OVR_STS_BIT         = 2;
   localparam int IRQ_UND_STS_BIT         = 1;
   localparam int IRQ_RUNT_STS_BIT        = 0;
   localparam logic [7:0] IRQ_RESET       = 8'h00;
   // cell lengths in bytes
   localparam logic [5:0] CELL_LEN_NARROW = 6'd53;
   localparam logic [5:0] CELL_LEN_WIDE   = 6'd54;
   localparam logic [5:0] CELL_LEN_SHORT  = 6'd52;
   // transmit fifo operating depths in cells
   localparam logic [4:0] DEPTH_CODE0     = 5'd16;
   localparam logic [4:0] DEPTH_CODE1     = 5'd12;
   localparam logic [4:0] DEPTH_CODE2     = 5'd8;
   localparam logic [4:0] DEPTH_CODE3     = 5'd4;

   // receive fifo events from the datapath
   typedef struct packed {
      logic overrun;
      logic underrun;
      logic runt;
   } rx_events_t;

   // decoded settings driven to the cell-bus datapath
   typedef struct packed {
      logic       cell_level;   // 1: cell-level handshake
      logic       multi_device; // 1: multi-device operation
      logic       wide_bus;     // 1: 16-bit data path
      logic [5:0] cell_bytes;   // bytes moved per cell
      logic [4:0] tx_depth;     // transmit fifo operating depth
   } cellbus_cfg_t;
endpackage

/* bench/rx_fifo_model.sv */
// behavioural receive fifo datapath that feeds events and levels to the bank
`timescale 1ns/100ps
module rx_fifo_model #(parameter int DEPTH = 2) (
   input  wire logic                    i_clk,   // device clock
   input  wire logic                    i_push,  // cell arrives from the line
   input  wire logic                    i_pop,   // cell taken by the cell bus
   input  wire logic                    i_runt,  // short cell seen on arrival
   input  wire logic                    i_clr,   // clear pulse from the bank
   output cellbus_regs_pkg::rx_events_t o_ev,    // one-cycle event pulses
   output logic                         o_full,  // fifo full level
   output logic                         o_empty  // fifo empty level
);
   int lvl = 0;                    // cells held, kept tiny so full is quick to reach
   initial o_ev = '0;              // no event before the first edge
   assign o_full  = (lvl == DEPTH);
   assign o_empty = (lvl == 0);
   // push at full overruns, pop at empty underruns; neither moves the level
   always @(posedge i_clk) begin
      o_ev <= '{overrun: i_push && o_full, underrun: i_pop && o_empty, runt: i_runt};
      if (i_clr) lvl <= 0;
      else lvl <= lvl + int'(i_push && !o_full) - int'(i_pop && !o_empty);
   end
endmodule // rx_fifo_model

/* bench/cellbus_regs_monitor.sv */
// port checker for the cell-bus register bank
`timescale 1ns/100ps
module cellbus_regs_monitor (
   input wire logic                          i_clk,
   input wire logic                          i_srst,
   input wire logic                          i_atm_mode,
   input wire logic [7:0]                    i_addr,
   input wire logic                          i_wr,
   input wire logic [7:0]                    i_wdata,
   input wire cellbus_regs_pkg::rx_events_t  i_rx_events,
   input wire logic                          i_rx_full,
   input wire cellbus_regs_pkg::cellbus_cfg_t o_cfg,
   input wire logic                          o_rx_fifo_clr,
   input wire logic                          o_irq,
   input wire logic                          o_ovr_risk
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // configuration write taken while in atm mode
   sequence s_cfg_wr; i_wr && i_addr == cellbus_regs_pkg::CFG_OFFSET && i_atm_mode; endsequence
   property p_hs; s_cfg_wr |=> o_cfg.cell_level == $past(i_wdata[5] && !i_wdata[4]); endproperty
   a_hs: assert property (p_hs) else $error("handshake level wrong");
   property p_bus; s_cfg_wr |=> {o_cfg.wide_bus, o_cfg.multi_device} == $past({i_wdata[0], i_wdata[4]}); endproperty
   a_bus: assert property (p_bus) else $error("width or multi wrong");
   property p_len; s_cfg_wr |=> o_cfg.cell_bytes == ($past(i_wdata[3]) ? 6'd52 : $past(i_wdata[0]) ? 6'd54 : 6'd53); endproperty
   a_len: assert property (p_len) else $error("cell length wrong");
   property p_depth; s_cfg_wr |=> o_cfg.tx_depth == 5'd16 - 5'd4 * 5'($past(i_wdata[2:1])); endproperty
   a_depth: assert property (p_depth) else $error("fifo depth wrong");
   // two cycles of clear-channel leave every field inactive
   property p_idle; !i_atm_mode ##1 !i_atm_mode |-> o_cfg == {3'b000, 6'd53, 5'd16} && !o_irq; endproperty
   a_idle: assert property (p_idle) else $error("fields active in clear channel");
   property p_clr; o_rx_fifo_clr |-> $past(i_wr && i_addr == 8'h6b && i_wdata[6] && i_atm_mode); endproperty
   a_clr: assert property (p_clr) else $error("fifo clear without cause");
   property p_risk; 1'b1 |=> o_ovr_risk == $past(i_atm_mode && i_rx_full); endproperty
   a_risk: assert property (p_risk) else $error("overrun warning wrong");
   // flags kept through clear-channel may raise the request again when atm mode returns
   property p_irq;
      $rose(o_irq) |-> $past(i_rx_events.overrun || i_rx_events.runt || i_wr) || !$past(i_atm_mode, 2);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule // cellbus_regs_monitor
bind cellbus_regs cellbus_regs_monitor mon (.i_clk(i_clk), .i_srst(i_srst), .i_atm_mode(i_atm_mode),
   .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .i_rx_events(i_rx_events), .i_rx_full(i_rx_full),
   .o_cfg(o_cfg), .o_rx_fifo_clr(o_rx_fifo_clr), .o_irq(o_irq), .o_ovr_risk(o_ovr_risk));

/* bench/cellbus_regs_tb_top.sv */
// self-checking bench for the cell-bus register bank
`timescale 1ns/100ps
module cellbus_regs_tb_top;
   logic i_clk = 0, i_srst = 1, i_atm = 1, i_wr = 0, i_rd = 0, push = 0, pop = 0, runt = 0;
   logic [7:0] i_addr = '0, i_wdata = '0, o_rdata, wd [4] = '{8'hc0, 8'h03, 8'h1c, 8'h2f};
   logic full, empty, o_clr, o_irq, o_ovr, o_und;
   cellbus_regs_pkg::rx_events_t ev;
   cellbus_regs_pkg::cellbus_cfg_t o_cfg;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   initial forever #5 i_clk = ~i_clk;
   cellbus_regs dut (.i_clk(i_clk), .i_srst(i_srst), .i_atm_mode(i_atm), .i_addr(i_addr), .i_wr(i_wr),
      .i_rd(i_rd), .i_wdata(i_wdata), .i_rx_events(ev), .i_rx_full(full), .i_rx_empty(empty), .o_rdata(o_rdata),
      .o_cfg(o_cfg), .o_rx_fifo_clr(o_clr), .o_irq(o_irq), .o_ovr_risk(o_ovr), .o_und_risk(o_und));
   rx_fifo_model fifo (.i_clk(i_clk), .i_push(push), .i_pop(pop), .i_runt(runt), .i_clr(o_clr),
      .o_ev(ev), .o_full(full), .o_empty(empty));
   // hang guard, far above the roughly 60 cycles the tests take
   always @(posedge i_clk) if (++cyc == 2000) begin n_mismatch++; report_and_stop; end
   task automatic tick(int n); repeat (n) @(posedge i_clk); #1; endtask
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin n_mismatch++; $display("Error %s expected %h seen %h", what, exp, seen); end
   endtask
   // a free edge first, so a strobe never rises in the step it fell
   task automatic wr(logic [7:0] a, logic [7:0] d);
      tick(1); i_wr = 1; i_addr = a; i_wdata = d; tick(1); i_wr = 0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
      tick(1); i_rd = 1; i_addr = a; tick(1); i_rd = 0; check(what, 16'(o_rdata), 16'(exp));
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      tick(6); i_srst = 0; tick(1);
      check("cfg reset", 16'(o_cfg), 16'({3'b010, 6'd53, 5'd16}));
      check("risk after reset", 16'({o_ovr, o_und}), 16'h1);
      rd(8'h6b, 8'h00, "irq reset"); rd(8'h6a, 8'h10, "cfg reset"); rd(8'h55, 8'h00, "unmapped");
      $display("test reset done");
      // every depth code, both widths, short cell and the handshake bit
      for (int c = 0; c < 4; c++) begin
         wr(8'h6a, wd[c]); rd(8'h6a, wd[c] & 8'h3f, "cfg readback");
         check("cfg fields", 16'(o_cfg), 16'({wd[c][5] & !wd[c][4], wd[c][4], wd[c][0],
            wd[c][3] ? 6'd52 : wd[c][0] ? 6'd54 : 6'd53, 5'd16 - 5'd4 * 5'(wd[c][2:1])}));
      end
      $display("test config done");
      wr(8'h6b, 8'h3f); rd(8'h6b, 8'h28, "irq enables");
      push = 1; tick(3); push = 0; tick(2); check("irq overrun", 16'(o_irq), 16'h1);
      check("risk at full", 16'({o_ovr, o_und}), 16'h2);
      rd(8'h6b, 8'h2c, "overrun flag"); check("irq drop", 16'(o_irq), 16'h0);
      rd(8'h6b, 8'h28, "overrun cleared");
      runt = 1; tick(1); runt = 0; tick(2); check("irq runt", 16'(o_irq), 16'h1);
      rd(8'h6b, 8'h29, "runt flag"); rd(8'h6b, 8'h28, "runt cleared");
      $display("test interrupts done");
      wr(8'h6b, 8'h40); check("fifo clear", 16'(o_clr), 16'h1);
      wr(8'h6b, 8'h70); check("no second clear", 16'(o_clr), 16'h0);
      pop = 1; tick(1); pop = 0; tick(2); check("no underrun irq", 16'(o_irq), 16'h0);
      rd(8'h6b, 8'h62, "underrun flag");
      $display("test fifo clear done");
      i_atm = 0; runt = 1; tick(1); runt = 0; tick(2);
      check("cfg inactive", 16'(o_cfg), 16'({3'b000, 6'd53, 5'd16}));
      rd(8'h6b, 8'h60, "event ignored");
      $display("test clear channel done");
      report_and_stop;
   end
endmodule // cellbus_regs_tb_top
